//--- sfc_pkg.sv
package sfc_pkg;
  // How it works
  // - binary check register starts at all ones
  // - xor each byte into low half
  // - shift right, xor polynomial if lsb set
  // - exactly eight bit steps per byte
  // - final register value is the check
  // - binary check sent low byte first
  // - ascii check sums bytes modulo 256
  // - ascii check negated, hex, high nibble first
  // - write-multiple request field order fixed
  // - silent gap ends binary frame
  // - broadcast address zero gets no reply

  // check arithmetic
  localparam logic [15:0] CRC_INIT    = 16'hffff;
  localparam logic [15:0] CRC_POLY    = 16'ha001;
  localparam logic [3:0]  CRC_STEPS   = 4'h8;
  localparam logic [15:0] LRC_INIT    = 16'h0000;

  // frame contents
  localparam logic [7:0]  FC_WR_MULTI = 8'h10;
  localparam logic [7:0]  ADDR_BCAST  = 8'h00;
  localparam logic [7:0]  CH_START    = 8'h3a;
  localparam logic [7:0]  CH_CR       = 8'h0d;
  localparam logic [7:0]  CH_LF       = 8'h0a;
  localparam logic [7:0]  CH_ZERO     = 8'h30;
  localparam logic [7:0]  CH_NINE     = 8'h39;
  localparam logic [7:0]  CH_A        = 8'h41;
  localparam logic [7:0]  CH_F        = 8'h46;
  localparam logic [7:0]  CH_A_M10    = 8'h37;
  localparam logic [3:0]  HEX_A_OFS   = 4'h9;

  // byte positions inside a request or reply
  localparam int ADDR_IDX     = 0;
  localparam int FC_IDX       = 1;
  localparam int START_HI_IDX = 2;
  localparam int START_LO_IDX = 3;
  localparam int CNT_HI_IDX   = 4;
  localparam int CNT_LO_IDX   = 5;
  localparam int BCNT_IDX     = 6;
  localparam int REQ_HDR_LEN  = 7;
  localparam int RSP_LEN      = 6;

  // end-of-frame silence
  localparam int GAP_US       = 10000;
  localparam int CLK_KHZ      = 25000;
  localparam int GAP_CYC_DEF  = GAP_US * CLK_KHZ / 1000;

  typedef enum logic [2:0] {
    TX_SOF = 3'h0,
    TX_HI  = 3'h1,
    TX_LO  = 3'h2,
    TX_CR  = 3'h3,
    TX_LF  = 3'h4
  } sfc_tx_e;

  typedef enum logic [1:0] {
    SL_RX = 2'h0,
    SL_WR = 2'h1,
    SL_TX = 2'h2
  } sfc_slv_e;

  typedef enum logic [1:0] {
    MS_IDLE = 2'h0,
    MS_TX   = 2'h1,
    MS_GAP  = 2'h2,
    MS_RX   = 2'h3
  } sfc_mst_e;

  // one shift step of the binary check
  function automatic logic [15:0] sfc_crc_step(input logic [15:0] a);
    return {1'b0, a[15:1]} ^ (a[0] ? CRC_POLY : 16'h0000);
  endfunction : sfc_crc_step

  // fold a byte into either accumulator
  function automatic logic [15:0] sfc_fold(input logic [15:0] a,
                                           input logic [7:0]  b,
                                           input logic        asc);
    return asc ? {8'h00, 8'(a[7:0] + b)} : a ^ {8'h00, b};
  endfunction : sfc_fold

  function automatic logic [15:0] sfc_acc_init(input logic asc);
    return asc ? LRC_INIT : CRC_INIT;
  endfunction : sfc_acc_init

  // residue over data plus check is zero when intact
  function automatic logic sfc_chk_ok(input logic [15:0] a,
                                      input logic        asc);
    return asc ? (a[7:0] == 8'h00) : (a == 16'h0000);
  endfunction : sfc_chk_ok

  function automatic logic [1:0] sfc_chk_len(input logic asc);
    return asc ? 2'h1 : 2'h2;
  endfunction : sfc_chk_len

  function automatic logic [7:0] sfc_hex_char(input logic [3:0] n);
    return (n < 4'ha) ? CH_ZERO + {4'h0, n} : CH_A_M10 + {4'h0, n};
  endfunction : sfc_hex_char

  // {valid, nibble} of an upper-case hex character
  function automatic logic [4:0] sfc_hex_val(input logic [7:0] c);
    if (c >= CH_ZERO && c <= CH_NINE) begin
      return {1'b1, c[3:0]};
    end else if (c >= CH_A && c <= CH_F) begin
      return {1'b1, 4'(c[3:0] + HEX_A_OFS)};
    end
    return 5'h00;
  endfunction : sfc_hex_val
endpackage : sfc_pkg

//--- sfc_link_if.sv
`timescale 1ns/100ps
// byte stream each way, valid/ready per direction
interface sfc_link_if;
  logic       m_valid;
  logic [7:0] m_data;
  logic       m_ready;
  logic       s_valid;
  logic [7:0] s_data;
  logic       s_ready;
  modport master (output m_valid, m_data, s_ready,
                  input  m_ready, s_valid, s_data);
  modport slave  (input  m_valid, m_data, s_ready,
                  output m_ready, s_valid, s_data);
endinterface : sfc_link_if

//--- sfc_master_end.sv
`timescale 1ns/100ps
module sfc_master_end
  import sfc_pkg::*;
#(
  parameter int GAP_CYC = GAP_CYC_DEF
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  sfc_link_if.master       link,
  input  wire logic        ascii_mode,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [7:0]  req_addr,
  input  wire logic [15:0] req_start,
  input  wire logic [7:0]  req_count,
  input  wire logic        wr_valid,
  output logic             wr_ready,
  input  wire logic [15:0] wr_data,
  output logic             done,
  output logic             done_ok
);
  localparam int IW = $clog2(GAP_CYC + 1);

  sfc_mst_e    st_q, st_d;
  sfc_tx_e     tx_q, tx_d;
  logic [15:0] acc_q, acc_d, acc_b, word_q, word_d, start_q, start_d;
  logic [3:0]  step_q, step_d, nib_q, nib_d;
  logic [8:0]  k_q, k_d, body_n, last_k;
  logic [7:0]  addr_q, addr_d, wcnt_q, wcnt_d, rcnt_q, rcnt_d;
  logic [7:0]  tx_byte, rx_byte;
  logic [IW-1:0] idle_q, idle_d;
  logic        have_q, have_d, nph_q, nph_d, bad_q, bad_d;
  logic        mism_q, mism_d, done_q, done_d, ok_q, ok_d;
  logic        need, data_k, tx_take, rx_take, byte_ok, gap_hit;
  logic [4:0]  hv;

  // request byte at position k, also the expected reply header
  function automatic logic [7:0] body(input logic [8:0] k);
    case (k)
      9'(ADDR_IDX):     body = addr_q;
      9'(FC_IDX):       body = FC_WR_MULTI;
      9'(START_HI_IDX): body = start_q[15:8];
      9'(START_LO_IDX): body = start_q[7:0];
      9'(CNT_HI_IDX):   body = 8'h00;
      9'(CNT_LO_IDX):   body = wcnt_q;
      9'(BCNT_IDX):     body = {wcnt_q[6:0], 1'b0};
      default:          body = k[0] ? word_q[15:8] : word_q[7:0];
    endcase
  endfunction : body

  assign body_n    = 9'(REQ_HDR_LEN) + {wcnt_q, 1'b0};
  assign last_k    = body_n + {7'h00, sfc_chk_len(ascii_mode)} - 9'h001;
  assign data_k    = (k_q >= 9'(REQ_HDR_LEN)) && (k_q < body_n);
  assign need      = data_k && !have_q;
  assign req_ready = (st_q == MS_IDLE);
  assign wr_ready  = (st_q == MS_TX) && need;
  assign link.m_valid = (st_q == MS_TX) && (step_q == 4'h0) && !need;
  assign link.s_ready = (st_q == MS_RX) && (step_q == 4'h0);
  assign tx_take   = link.m_valid && link.m_ready;
  assign rx_take   = link.s_valid && link.s_ready;
  assign gap_hit   = (idle_q == IW'(GAP_CYC));
  assign done      = done_q;
  assign done_ok   = ok_q;

  // byte and character on the wire
  always_comb begin
    if (k_q < body_n) begin
      tx_byte = body(k_q);
    end else if (ascii_mode) begin
      tx_byte = 8'h00 - acc_q[7:0];
    end else begin
      tx_byte = (k_q == body_n) ? acc_q[7:0] : acc_q[15:8];
    end
    case (tx_q)
      TX_SOF:  link.m_data = CH_START;
      TX_HI:   link.m_data = ascii_mode ? sfc_hex_char(tx_byte[7:4])
                                        : tx_byte;
      TX_LO:   link.m_data = sfc_hex_char(tx_byte[3:0]);
      TX_CR:   link.m_data = CH_CR;
      TX_LF:   link.m_data = CH_LF;
      default: link.m_data = CH_LF;
    endcase
  end

  // sequencer next state
  always_comb begin
    st_d = st_q; tx_d = tx_q; acc_d = acc_q; step_d = step_q;
    k_d = k_q; have_d = have_q; word_d = word_q; addr_d = addr_q;
    start_d = start_q; wcnt_d = wcnt_q; rcnt_d = rcnt_q;
    idle_d = idle_q; nib_d = nib_q; nph_d = nph_q; bad_d = bad_q;
    mism_d = mism_q; done_d = 1'b0; ok_d = ok_q;
    byte_ok = 1'b0; rx_byte = link.s_data; hv = 5'h00;
    acc_b = acc_q;
    if (step_q != 4'h0) begin
      acc_d  = sfc_crc_step(acc_q);
      step_d = step_q - 4'h1;
    end
    case (st_q)
      MS_IDLE: if (req_valid) begin
        st_d = MS_TX; addr_d = req_addr; start_d = req_start;
        wcnt_d = req_count; k_d = 9'h000; have_d = 1'b0;
        tx_d = ascii_mode ? TX_SOF : TX_HI;
        acc_d = sfc_acc_init(ascii_mode);
      end
      MS_TX: begin
        if (wr_valid && wr_ready) begin
          word_d = wr_data;
          have_d = 1'b1;
        end
        if (tx_take) begin
          case (tx_q)
            TX_SOF: tx_d = TX_HI;
            TX_HI:  tx_d = ascii_mode ? TX_LO : TX_HI;
            TX_CR:  tx_d = TX_LF;
            default: tx_d = tx_q;
          endcase
          if ((tx_q == TX_HI && !ascii_mode) || tx_q == TX_LO) begin
            if (k_q < body_n) begin
              acc_d  = sfc_fold(acc_q, tx_byte, ascii_mode);
              step_d = ascii_mode ? 4'h0 : CRC_STEPS;
            end
            if (data_k && !k_q[0]) have_d = 1'b0;
            if (k_q == last_k) begin
              if (ascii_mode) tx_d = TX_CR;
              else begin st_d = MS_GAP; idle_d = '0; end
            end else begin
              k_d = k_q + 9'h001; tx_d = TX_HI;
            end
          end
          if (tx_q == TX_LF) begin st_d = MS_GAP; idle_d = '0; end
        end
      end
      MS_GAP: if (gap_hit) begin
        if (addr_q == ADDR_BCAST) begin
          st_d = MS_IDLE; done_d = 1'b1; ok_d = 1'b1;
        end else begin
          st_d = MS_RX; idle_d = '0; rcnt_d = 8'h00;
          mism_d = 1'b0; bad_d = 1'b0; nph_d = 1'b0;
        end
      end else idle_d = idle_q + IW'(1);
      MS_RX: begin
        idle_d = rx_take ? '0 : (gap_hit ? idle_q : idle_q + IW'(1));
        if (rx_take && !ascii_mode) byte_ok = 1'b1;
        else if (rx_take) begin
          hv = sfc_hex_val(link.s_data);
          if (link.s_data == CH_START) begin
            rcnt_d = 8'h00; mism_d = 1'b0; bad_d = 1'b0; nph_d = 1'b0;
          end else if (hv[4]) begin
            if (nph_q) begin byte_ok = 1'b1; rx_byte = {nib_q, hv[3:0]}; end
            nib_d = hv[3:0]; nph_d = ~nph_q;
          end else if (link.s_data != CH_CR && link.s_data != CH_LF) begin
            bad_d = 1'b1;
          end
        end
        if (byte_ok) begin
          if (rcnt_q == 8'h00) acc_b = sfc_acc_init(ascii_mode);
          acc_d  = sfc_fold(acc_b, rx_byte, ascii_mode);
          step_d = ascii_mode ? 4'h0 : CRC_STEPS;
          if (rcnt_q < 8'(RSP_LEN) && rx_byte != body({1'b0, rcnt_q}))
            mism_d = 1'b1;
          if (rcnt_q != 8'hff) rcnt_d = rcnt_q + 8'h01;
        end
        if ((ascii_mode && rx_take && link.s_data == CH_LF) ||
            (!ascii_mode && gap_hit && rcnt_q != 8'h00)) begin
          st_d = MS_IDLE; done_d = 1'b1;
          ok_d = !bad_q && !mism_q && sfc_chk_ok(acc_q, ascii_mode) &&
                 rcnt_q == 8'(RSP_LEN) + {6'h00, sfc_chk_len(ascii_mode)};
        end else if (gap_hit) begin
          st_d = MS_IDLE; done_d = 1'b1; ok_d = 1'b0;
        end
      end
      default: st_d = MS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= MS_IDLE; tx_q <= TX_SOF; acc_q <= CRC_INIT;
      step_q <= 4'h0; k_q <= 9'h000; have_q <= 1'b0; word_q <= 16'h0000;
      addr_q <= 8'h00; start_q <= 16'h0000; wcnt_q <= 8'h00;
      rcnt_q <= 8'h00; idle_q <= '0; nib_q <= 4'h0; nph_q <= 1'b0;
      bad_q <= 1'b0; mism_q <= 1'b0; done_q <= 1'b0; ok_q <= 1'b0;
    end else begin
      st_q <= st_d; tx_q <= tx_d; acc_q <= acc_d; step_q <= step_d;
      k_q <= k_d; have_q <= have_d; word_q <= word_d; addr_q <= addr_d;
      start_q <= start_d; wcnt_q <= wcnt_d; rcnt_q <= rcnt_d;
      idle_q <= idle_d; nib_q <= nib_d; nph_q <= nph_d; bad_q <= bad_d;
      mism_q <= mism_d; done_q <= done_d; ok_q <= ok_d;
    end
  end
endmodule : sfc_master_end

//--- sfc_slave_end.sv
`timescale 1ns/100ps
module sfc_slave_end
  import sfc_pkg::*;
#(
  parameter int GAP_CYC   = GAP_CYC_DEF,
  parameter int DEPTH     = 64,
  parameter int BUF_DEPTH = 2,
  parameter int BUF_W     = 32
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  sfc_link_if.slave        link,
  input  wire logic        ascii_mode,
  input  wire logic [7:0]  own_addr,
  output logic             wr_valid,
  input  wire logic        wr_ready,
  output logic [15:0]      wr_reg,
  output logic [15:0]      wr_data,
  output logic             frame_drop
);
  localparam int IW  = $clog2(GAP_CYC + 1);
  localparam int AW  = $clog2(DEPTH);
  localparam int BPW = $clog2(BUF_DEPTH);

  sfc_slv_e    st_q, st_d;
  sfc_tx_e     tx_q, tx_d;
  logic [15:0] acc_q, acc_d, acc_b;
  logic [3:0]  step_q, step_d, nib_q, nib_d;
  logic [7:0]  cnt_q, cnt_d, ri_q, ri_d, wi_q, wi_d;
  logic [2:0]  k_q, k_d, last_k;
  logic [IW-1:0] idle_q, idle_d;
  logic        nph_q, nph_d, bad_q, bad_d, drop_q, drop_d;
  logic [7:0]  mem [DEPTH];
  logic        mem_we, byte_ok, fr_end, rx_good, rx_take, tx_take;
  logic [7:0]  byte_v, tx_byte;
  logic [8:0]  exp_len;
  logic [15:0] start_a;
  logic [4:0]  hv;
  logic [BUF_W-1:0] bq [BUF_DEPTH];
  logic [BPW-1:0]   bwp_q, bwp_d, brp_q, brp_d;
  logic [BPW:0]     bcnt_q, bcnt_d;
  logic        push, pop, buf_full;
  logic [BUF_W-1:0] push_w;

  assign rx_take = link.m_valid && link.m_ready;
  assign tx_take = link.s_valid && link.s_ready;
  assign link.m_ready = (st_q == SL_RX) && (step_q == 4'h0);
  assign link.s_valid = (st_q == SL_TX) && (step_q == 4'h0);
  assign last_k   = 3'(RSP_LEN) + {1'b0, sfc_chk_len(ascii_mode)} - 3'h1;
  assign start_a  = {mem[START_HI_IDX], mem[START_LO_IDX]};
  assign frame_drop = drop_q;

  // request acceptance test at end of frame
  assign exp_len = 9'(REQ_HDR_LEN) + {1'b0, mem[BCNT_IDX]} +
                   {7'h00, sfc_chk_len(ascii_mode)};
  assign rx_good = !bad_q && sfc_chk_ok(acc_q, ascii_mode) &&
                   {1'b0, cnt_q} == exp_len &&
                   mem[FC_IDX] == FC_WR_MULTI &&
                   mem[CNT_HI_IDX] == 8'h00 &&
                   mem[BCNT_IDX] == {mem[CNT_LO_IDX][6:0], 1'b0} &&
                   (mem[ADDR_IDX] == own_addr ||
                    mem[ADDR_IDX] == ADDR_BCAST);

  // reply byte and character
  always_comb begin
    if (k_q < 3'(RSP_LEN)) begin
      tx_byte = mem[k_q];
    end else if (ascii_mode) begin
      tx_byte = 8'h00 - acc_q[7:0];
    end else begin
      tx_byte = (k_q == 3'(RSP_LEN)) ? acc_q[7:0] : acc_q[15:8];
    end
    case (tx_q)
      TX_SOF:  link.s_data = CH_START;
      TX_HI:   link.s_data = ascii_mode ? sfc_hex_char(tx_byte[7:4])
                                        : tx_byte;
      TX_LO:   link.s_data = sfc_hex_char(tx_byte[3:0]);
      TX_CR:   link.s_data = CH_CR;
      TX_LF:   link.s_data = CH_LF;
      default: link.s_data = CH_LF;
    endcase
  end

  // receive, write-out and reply sequencing
  always_comb begin
    st_d = st_q; tx_d = tx_q; acc_d = acc_q; step_d = step_q;
    cnt_d = cnt_q; nib_d = nib_q; nph_d = nph_q; bad_d = bad_q;
    idle_d = idle_q; k_d = k_q; ri_d = ri_q; wi_d = wi_q;
    drop_d = 1'b0; mem_we = 1'b0; push = 1'b0;
    byte_ok = 1'b0; byte_v = link.m_data; fr_end = 1'b0;
    hv = 5'h00; acc_b = acc_q;
    push_w = {start_a + {8'h00, wi_q}, mem[ri_q[AW-1:0]],
              mem[AW'(ri_q + 8'h01)]};
    if (step_q != 4'h0) begin
      acc_d  = sfc_crc_step(acc_q);
      step_d = step_q - 4'h1;
    end
    case (st_q)
      SL_RX: begin
        idle_d = rx_take ? '0
               : ((idle_q == IW'(GAP_CYC)) ? idle_q : idle_q + IW'(1));
        if (rx_take && !ascii_mode) byte_ok = 1'b1;
        else if (rx_take) begin
          hv = sfc_hex_val(link.m_data);
          if (link.m_data == CH_START) begin
            cnt_d = 8'h00; nph_d = 1'b0; bad_d = 1'b0;
          end else if (link.m_data == CH_LF) begin
            fr_end = 1'b1;
          end else if (hv[4]) begin
            if (nph_q) begin byte_ok = 1'b1; byte_v = {nib_q, hv[3:0]}; end
            nib_d = hv[3:0]; nph_d = ~nph_q;
          end else if (link.m_data != CH_CR) begin
            bad_d = 1'b1;
          end
        end
        if (!ascii_mode && cnt_q != 8'h00 && idle_q == IW'(GAP_CYC))
          fr_end = 1'b1;
        if (byte_ok) begin
          if (cnt_q == 8'h00) acc_b = sfc_acc_init(ascii_mode);
          if (cnt_q == 8'(DEPTH)) bad_d = 1'b1;
          else begin mem_we = 1'b1; cnt_d = cnt_q + 8'h01; end
          acc_d  = sfc_fold(acc_b, byte_v, ascii_mode);
          step_d = ascii_mode ? 4'h0 : CRC_STEPS;
        end
        if (fr_end) begin
          cnt_d = 8'h00; nph_d = 1'b0; bad_d = 1'b0;
          if (rx_good) begin
            st_d = SL_WR; ri_d = 8'(REQ_HDR_LEN); wi_d = 8'h00;
          end else drop_d = 1'b1;
        end
      end
      SL_WR: begin
        if (wi_q == mem[CNT_LO_IDX]) begin
          st_d = (mem[ADDR_IDX] == ADDR_BCAST) ? SL_RX : SL_TX;
          tx_d = ascii_mode ? TX_SOF : TX_HI;
          k_d = 3'h0;
          acc_d = sfc_acc_init(ascii_mode);
        end else if (!buf_full) begin
          push = 1'b1; ri_d = ri_q + 8'h02; wi_d = wi_q + 8'h01;
        end
      end
      SL_TX: if (tx_take) begin
        case (tx_q)
          TX_SOF: tx_d = TX_HI;
          TX_HI:  tx_d = ascii_mode ? TX_LO : TX_HI;
          TX_CR:  tx_d = TX_LF;
          default: tx_d = tx_q;
        endcase
        if ((tx_q == TX_HI && !ascii_mode) || tx_q == TX_LO) begin
          if (k_q < 3'(RSP_LEN)) begin
            acc_d  = sfc_fold(acc_q, tx_byte, ascii_mode);
            step_d = ascii_mode ? 4'h0 : CRC_STEPS;
          end
          if (k_q == last_k) begin
            if (ascii_mode) tx_d = TX_CR;
            else begin st_d = SL_RX; idle_d = '0; end
          end else begin
            k_d = k_q + 3'h1; tx_d = TX_HI;
          end
        end
        if (tx_q == TX_LF) begin st_d = SL_RX; idle_d = '0; end
      end
      default: st_d = SL_RX;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= SL_RX; tx_q <= TX_SOF; acc_q <= CRC_INIT; step_q <= 4'h0;
      cnt_q <= 8'h00; nib_q <= 4'h0; nph_q <= 1'b0; bad_q <= 1'b0;
      idle_q <= '0; k_q <= 3'h0; ri_q <= 8'h00; wi_q <= 8'h00;
      drop_q <= 1'b0;
    end else begin
      st_q <= st_d; tx_q <= tx_d; acc_q <= acc_d; step_q <= step_d;
      cnt_q <= cnt_d; nib_q <= nib_d; nph_q <= nph_d; bad_q <= bad_d;
      idle_q <= idle_d; k_q <= k_d; ri_q <= ri_d; wi_q <= wi_d;
      drop_q <= drop_d;
    end
  end

  // frame byte store
  always_ff @(posedge clk) begin
    if (mem_we) mem[cnt_q[AW-1:0]] <= byte_v;
  end

  // write-out buffer toward the register user
  assign buf_full = (bcnt_q == (BPW+1)'(BUF_DEPTH));
  assign wr_valid = (bcnt_q != '0);
  assign pop      = wr_valid && wr_ready;
  assign wr_reg   = bq[brp_q][BUF_W-1:16];
  assign wr_data  = bq[brp_q][15:0];

  always_comb begin
    bwp_d  = push ? bwp_q + BPW'(1) : bwp_q;
    brp_d  = pop ? brp_q + BPW'(1) : brp_q;
    bcnt_d = bcnt_q + (BPW+1)'(push) - (BPW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bwp_q <= '0; brp_q <= '0; bcnt_q <= '0;
    end else begin
      bwp_q <= bwp_d; brp_q <= brp_d; bcnt_q <= bcnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) bq[bwp_q] <= push_w;
  end
endmodule : sfc_slave_end

//--- sfc_link_props.sv
`timescale 1ns/100ps
module sfc_link_props
  import sfc_pkg::*;
#(
  parameter int GAP_CYC = GAP_CYC_DEF
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       ascii_mode,
  input wire logic       m_valid,
  input wire logic [7:0] m_data,
  input wire logic       m_ready,
  input wire logic       s_valid,
  input wire logic [7:0] s_data,
  input wire logic       s_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  int         idle_q, idle_d;
  logic [7:0] adr_q, adr_d;
  logic       bc_q, bc_d, m_tk, s_tk, fst;
  // idle span, frame start, address of the current frame
  always_comb begin
    m_tk = m_valid && m_ready;
    s_tk = s_valid && s_ready;
    fst = m_tk && idle_q > GAP_CYC;
    idle_d = (m_tk || s_tk) ? 0 : idle_q + 32'(idle_q <= GAP_CYC);
    adr_d = fst ? m_data : adr_q;
    bc_d = !ascii_mode && (fst ? m_data == 8'h00 : bc_q);
    if (!rst_n) begin
      idle_d = GAP_CYC + 1;
      bc_d = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    idle_q <= idle_d;
    adr_q <= adr_d;
    bc_q <= bc_d;
  end
  req_hold_a: assert property (m_valid && !m_ready |=>
    m_valid && $stable(m_data)) else $error("request char changed");
  rsp_hold_a: assert property (s_valid && !s_ready |=>
    s_valid && $stable(s_data)) else $error("reply char changed");
  req_steps_a: assert property (!ascii_mode && m_tk |=>
    !m_ready [*8]) else $error("slave took byte during bit steps");
  rsp_steps_a: assert property (!ascii_mode && s_tk |=>
    !s_ready [*8]) else $error("master took byte during bit steps");
  req_hex_a: assert property (ascii_mode && m_valid |-> m_data inside
    {8'h3a, 8'h0d, 8'h0a, [8'h30:8'h39], [8'h41:8'h46]})
    else $error("bad request character");
  rsp_hex_a: assert property (ascii_mode && s_valid |-> s_data inside
    {8'h3a, 8'h0d, 8'h0a, [8'h30:8'h39], [8'h41:8'h46]})
    else $error("bad reply character");
  req_crlf_a: assert property (ascii_mode && m_tk && m_data == 8'h0d
    |=> ##[0:3] (m_valid && m_data == 8'h0a)) else $error("no line feed");
  asc_start_a: assert property (ascii_mode && fst |-> m_data == 8'h3a)
    else $error("ascii frame without start char");
  bcast_quiet_a: assert property (!(bc_q && s_valid))
    else $error("reply to broadcast");
  rsp_addr_a: assert property (!ascii_mode && s_tk && idle_q > GAP_CYC
    |-> s_data == adr_q) else $error("reply address wrong");
  cover property (fst && !ascii_mode && m_data != 8'h00);
  cover property (fst && !ascii_mode && m_data == 8'h00);
  cover property (ascii_mode && m_tk && m_data == 8'h0d);
  cover property (s_valid && !s_ready);
endmodule : sfc_link_props

//--- serial_frame_check_unit_tb.sv
`timescale 1ns/100ps
module serial_frame_check_unit_tb;
  import sfc_pkg::*;
  localparam int GAP = 20;
  typedef struct packed {
    logic        asc;
    logic [7:0]  adr;
    logic [15:0] st;
    logic [7:0]  cnt;
    logic [47:0] w;
  } sfc_row_s;
  logic        clk = 1'b0, rst_n = 1'b0, ascii_mode = 1'b0, req_valid = 1'b0;
  logic        mw_valid = 1'b0, wr_ready = 1'b1, req_ready, mw_ready, done;
  logic        done_ok, sw_valid, frame_drop, s2_valid, drop2;
  logic [7:0]  req_addr = 8'h00, req_count = 8'h00, own_addr = 8'h01;
  logic [15:0] req_start = 16'h0000, mw_data = 16'h0000, wr_reg, wr_data;
  logic [7:0]  mq[$], sq[$], pl[$];
  logic [31:0] wq[$];
  int          err_total = 0, samples_checked = 0, drops = 0, s2_busy = 0;
  int          drops1 = 0;
  sfc_row_s    rows[6];
  sfc_link_if  lk();
  sfc_link_if  lk2();
  sfc_master_end #(.GAP_CYC(GAP)) sfc_master_end_i (
    .clk, .rst_n, .link(lk.master), .ascii_mode, .req_valid, .req_ready,
    .req_addr, .req_start, .req_count, .wr_valid(mw_valid),
    .wr_ready(mw_ready), .wr_data(mw_data), .done, .done_ok);
  sfc_slave_end #(.GAP_CYC(GAP)) sfc_slave_end_i (
    .clk, .rst_n, .link(lk.slave), .ascii_mode, .own_addr,
    .wr_valid(sw_valid), .wr_ready, .wr_reg, .wr_data, .frame_drop);
  sfc_slave_end #(.GAP_CYC(GAP)) sfc_slave_end_i2 (
    .clk, .rst_n, .link(lk2.slave), .ascii_mode(1'b0), .own_addr(8'h01),
    .wr_valid(s2_valid), .wr_ready(1'b1), .wr_reg(), .wr_data(),
    .frame_drop(drop2));
  sfc_link_props #(.GAP_CYC(GAP)) sfc_link_props_i (
    .clk, .rst_n, .ascii_mode, .m_valid(lk.m_valid), .m_data(lk.m_data),
    .m_ready(lk.m_ready), .s_valid(lk.s_valid), .s_data(lk.s_data),
    .s_ready(lk.s_ready));
  always #20 clk = ~clk;
  // capture link chars, write-outs and second-link activity
  always @(posedge clk) begin
    if (lk.m_valid && lk.m_ready) mq.push_back(lk.m_data);
    if (lk.s_valid && lk.s_ready) sq.push_back(lk.s_data);
    if (sw_valid && wr_ready) wq.push_back({wr_reg, wr_data});
    drops += int'(drop2 === 1'b1);
    drops1 += int'(frame_drop === 1'b1);
    s2_busy += int'(s2_valid === 1'b1 || lk2.s_valid === 1'b1);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  function automatic logic [15:0] crc16(input logic [7:0] p[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (p[i]) begin
      c ^= {8'h00, p[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction : crc16
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction : hx
  // expected wire image of pl, compared char by char
  task automatic cmp_frame(input logic asc, ref logic [7:0] w[$]);
    logic [7:0]  e[$];
    logic [15:0] c;
    logic [7:0]  s;
    c = crc16(pl);
    s = 8'h00;
    foreach (pl[i]) s += pl[i];
    s = -s;
    if (asc) e = {8'h3a};
    else e = pl;
    if (asc) foreach (pl[i]) e = {e, hx(pl[i][7:4]), hx(pl[i][3:0])};
    if (asc) e = {e, hx(s[7:4]), hx(s[3:0]), 8'h0d, 8'h0a};
    else e = {e, c[7:0], c[15:8]};
    chk(w.size(), e.size());
    foreach (e[i]) chk(w[i], e[i]);
    w = {};
  endtask : cmp_frame
  task automatic run(input sfc_row_s r, input logic stall);
    logic hit;
    hit = (r.adr == own_addr) || (r.adr == 8'h00);
    @(posedge clk);
    ascii_mode <= r.asc;
    req_addr <= r.adr;
    req_start <= r.st;
    req_count <= r.cnt;
    req_valid <= 1'b1;
    wr_ready <= !stall;
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    for (int i = 0; i < r.cnt; i++) begin
      mw_data <= r.w[47-16*i -: 16];
      mw_valid <= 1'b1;
      do @(posedge clk); while (mw_ready !== 1'b1);
    end
    mw_valid <= 1'b0;
    mw_data <= ~mw_data;
    if (stall) begin
      do @(posedge clk); while (sw_valid !== 1'b1);
      repeat (4) @(posedge clk);
      wr_ready <= 1'b1;
    end
    do @(posedge clk); while (done !== 1'b1);
    chk(done_ok, hit);
    repeat (GAP) @(posedge clk); // idle past a frame gap
    pl = {r.adr, 8'h10, r.st[15:8], r.st[7:0], 8'h00, r.cnt, 8'(2 * r.cnt)};
    for (int i = 0; i < r.cnt; i++) pl = {pl, r.w[47-16*i -: 8], r.w[39-16*i -: 8]};
    cmp_frame(r.asc, mq);
    pl = pl[0:5];
    if (hit && r.adr != 8'h00) cmp_frame(r.asc, sq);
    else chk(sq.size(), 0);
    chk(wq.size(), hit ? r.cnt : 0);
    chk(drops1, hit ? 0 : 1);
    drops1 = 0;
    foreach (wq[i]) chk(wq[i], {16'(r.st + i), r.w[47-16*i -: 16]});
    wq = {};
  endtask : run
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    give_verdict();
  end
  // reset, table of requests, stalled write-out, corrupted frame
  initial begin
    logic [15:0] c;
    lk2.m_valid = 1'b0;
    lk2.m_data = 8'h00;
    lk2.s_ready = 1'b1;
    rows = '{'{1'b0, 8'h01, 16'h0500, 8'h02, 48'h1388_0fa0_0000},
             '{1'b1, 8'h01, 16'h0500, 8'h02, 48'h1388_0fa0_0000},
             '{1'b0, 8'h00, 16'h0123, 8'h01, 48'habcd_0000_0000},
             '{1'b0, 8'h05, 16'h0200, 8'h01, 48'h5555_0000_0000},
             '{1'b1, 8'h00, 16'hfffe, 8'h03, 48'h0001_8000_ffff},
             '{1'b1, 8'h09, 16'h0300, 8'h02, 48'h1111_2222_0000}};
    repeat (4) @(posedge clk);
    chk({req_ready, done, done_ok, sw_valid, frame_drop, lk.m_ready,
         lk.m_valid, lk.s_valid}, 32'h84);
    rst_n <= 1'b1;
    foreach (rows[i]) run(rows[i], 1'b0);
    run('{1'b0, 8'h01, 16'h0040, 8'h03, 48'h00ff_ff00_a5a5}, 1'b1);
    pl = {8'h01, 8'h10, 8'h00, 8'h20, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34};
    c = crc16(pl);
    pl = {pl, c[7:0] ^ 8'h01, c[15:8]};
    foreach (pl[i]) begin
      lk2.m_data <= pl[i];
      lk2.m_valid <= 1'b1;
      do @(posedge clk); while (lk2.m_ready !== 1'b1);
    end
    lk2.m_valid <= 1'b0;
    lk2.m_data <= ~lk2.m_data;
    repeat (GAP + 12) @(posedge clk);
    chk(drops, 1);
    chk(s2_busy, 0);
    give_verdict();
  end
endmodule : serial_frame_check_unit_tb
